// file: verilog/sync_rate_pkg.sv
// Shared constants and types of the synchronous rate divider.
// Assumes a Wishbone slave with byte addresses and 32-bit data words.
package sync_rate_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRANSFER_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // Field positions in sync_clock_ctrl
  localparam int unsigned ULTRA_BIT = 7;
  localparam int unsigned SCF_LSB = 4;
  localparam int unsigned CCF_LSB = 0;

  // Field positions in sync_transfer_ctrl
  localparam int unsigned TP_LSB = 5;
  localparam int unsigned OFFSET_LSB = 0;

  // Field positions in the status word
  localparam int unsigned STAT_PENDING_BIT = 0;
  localparam int unsigned STAT_ULTRA_BIT = 1;
  localparam int unsigned STAT_SCF_BAD_BIT = 2;
  localparam int unsigned STAT_CCF_BAD_BIT = 3;

  // Reset values
  localparam logic [7:0] CLOCK_CTRL_RST = 8'h00;
  localparam logic [7:0] TRANSFER_CTRL_RST = 8'h00;

  // Factor codes shared by the sync and core clock fields
  localparam logic [2:0] FACTOR_DIV1 = 3'h1;
  localparam logic [2:0] FACTOR_DIV2 = 3'h3;
  localparam logic [2:0] FACTOR_DIV4 = 3'h5;

  // Divide ratios
  localparam logic [3:0] RATIO_1 = 4'h1;
  localparam logic [3:0] RATIO_2 = 4'h2;
  localparam logic [3:0] RATIO_4 = 4'h4;

  // Receive slot every four sync ticks
  localparam logic [3:0] RX_RATIO = 4'h4;

  // Transfer period code 000 means divide by four; each step adds one
  localparam logic [3:0] TP_BASE = 4'h4;

  // Outside Ultra mode the sync clock is never divided by less than this
  localparam logic [3:0] NON_ULTRA_MIN_RATIO = 4'h2;

  typedef struct packed {
    logic [3:0] syncRatio;
    logic [3:0] coreRatio;
    logic [3:0] sendRatio;
    logic ultra;
    logic [4:0] offset;
  } rate_cfg_t;

endpackage

// file: verilog/div_tick.sv
// Programmable divider that turns a stream of advance pulses into ticks.
// Assumes divisor is stable while advance pulses arrive; 0 acts as 1.
`timescale 1ns/1ps
module div_tick
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] divisor,
  input wire logic advance,
  output logic tick
);

  logic [3:0] count;
  logic [3:0] lastCount;

  assign lastCount = (divisor == 4'h0) ? 4'h0 : 4'(divisor - 4'h1);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count <= 4'h0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (advance)
      begin
        if (count >= lastCount)
        begin
          count <= 4'h0;
          tick <= 1'b1;
        end
        else
        begin
          count <= 4'(count + 4'h1);
        end
      end
    end
  end

endmodule // div_tick

// file: verilog/sync_scsi_rate_divider.sv
// Synchronous SCSI rate divider with its two control registers.
// Assumes mclk is the SCSI input clock; registers sit on classic Wishbone.
// Assumes syncXferActive is high for the whole of a synchronous transfer.
//
// Notes on behaviour
// - Sync clock is SCSI clock divided by the sync clock factor field; outside Ultra the block divides by two for code 001.
// - Receive slots come at one quarter of the sync divider rate.
// - Core clock is SCSI clock divided by core clock factor field.
// - Send period further divides the sync clock by the period divisor.
// - Codes 001 and 011 divide by one and two; period 000 by four.
// - Code 101 divides by four in both clock factor fields.
// - Ultra transfers only with Ultra enable set and an 80 MHz clock.
// - Receive slots stay at 50 ns capability whatever the send period.
// - Send intervals reach 50, 100 or 200 ns by divider setting.
// - Transfer register holds offset and period, writable and readable.
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module sync_scsi_rate_divider
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic syncXferActive,
  input wire logic scsiClock80,
  output logic syncTick,
  output logic coreTick,
  output logic rxSlot,
  output logic txSlot,
  output logic ultraActive,
  output logic [4:0] syncOffset
);

  logic [7:0] clockCtrl;
  logic [7:0] transferCtrl;
  sync_rate_pkg::rate_cfg_t requested;
  sync_rate_pkg::rate_cfg_t active;
  logic [3:0] activeSync;
  logic [3:0] activeCore;
  logic [3:0] activeSend;
  logic activeUltra;
  logic [4:0] activeOffset;
  logic clockWrite;
  logic transferWrite;
  logic scfBad;
  logic ccfBad;
  logic pending;
  logic busWrite;
  logic busRead;
  logic [3:0] scfRatio;
  logic [3:0] ccfRatio;
  logic [3:0] syncRatioGated;
  logic [2:0] scfCode;
  logic [2:0] ccfCode;
  logic [2:0] tpCode;
  logic ultraWanted;
  logic [31:0] next_dat;
  logic [31:0] statusWord;

  // Maps a clock factor code to its divide ratio
  function automatic logic [3:0] factorRatio(input logic [2:0] code);
    logic [3:0] ratio;
    ratio = sync_rate_pkg::RATIO_1;
    case (code)
      sync_rate_pkg::FACTOR_DIV1: ratio = sync_rate_pkg::RATIO_1;
      sync_rate_pkg::FACTOR_DIV2: ratio = sync_rate_pkg::RATIO_2;
      sync_rate_pkg::FACTOR_DIV4: ratio = sync_rate_pkg::RATIO_4;
      default: ratio = sync_rate_pkg::RATIO_1;
    endcase
    return ratio;
  endfunction

  // Flags codes that have no defined ratio
  function automatic logic factorBad(input logic [2:0] code);
    logic bad;
    bad = 1'b1;
    case (code)
      sync_rate_pkg::FACTOR_DIV1: bad = 1'b0;
      sync_rate_pkg::FACTOR_DIV2: bad = 1'b0;
      sync_rate_pkg::FACTOR_DIV4: bad = 1'b0;
      default: bad = 1'b1;
    endcase
    return bad;
  endfunction

  // Wishbone request decode
  assign busWrite = cyc_i && stb_i && we_i && !ack_o;
  assign busRead = cyc_i && stb_i && !we_i && !ack_o;

  // Byte-lane qualified register strobes
  assign clockWrite = busWrite && sel_i[0] &&
                      adr_i == sync_rate_pkg::ADDR_CLOCK_CTRL;
  assign transferWrite = busWrite && sel_i[0] &&
                         adr_i == sync_rate_pkg::ADDR_TRANSFER_CTRL;

  // Single-cycle ack, dropped the cycle after it was given
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ack_o <= 1'b0;
    end
    else
    begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Clock control register, low byte lane only
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      clockCtrl <= sync_rate_pkg::CLOCK_CTRL_RST;
    end
    else if (clockWrite)
    begin
      clockCtrl <= dat_i[7:0];
    end
  end

  // Transfer control register: offset and period, read back for RMW
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      transferCtrl <= sync_rate_pkg::TRANSFER_CTRL_RST;
    end
    else if (transferWrite)
    begin
      transferCtrl <= dat_i[7:0];
    end
  end

  // Field extraction
  assign scfCode = clockCtrl[sync_rate_pkg::SCF_LSB +: 3];
  assign ccfCode = clockCtrl[sync_rate_pkg::CCF_LSB +: 3];
  assign tpCode = transferCtrl[sync_rate_pkg::TP_LSB +: 3];

  assign scfRatio = factorRatio(scfCode);
  assign ccfRatio = factorRatio(ccfCode);
  assign scfBad = factorBad(scfCode);
  assign ccfBad = factorBad(ccfCode);

  // Ultra only with the enable bit and an 80 MHz SCSI clock
  assign ultraWanted = clockCtrl[sync_rate_pkg::ULTRA_BIT] &&
                       scsiClock80;

  // Outside Ultra the sync clock is slowed to at least divide by two,
  // which keeps the send interval at 100 ns or more from 80 MHz
  always_comb
  begin
    syncRatioGated = scfRatio;
    if (!ultraWanted && scfRatio < sync_rate_pkg::NON_ULTRA_MIN_RATIO)
    begin
      syncRatioGated = sync_rate_pkg::NON_ULTRA_MIN_RATIO;
    end
  end

  // Settings as software currently asks for them
  always_comb
  begin
    requested.syncRatio = syncRatioGated;
    requested.coreRatio = ccfRatio;
    requested.sendRatio = 4'(sync_rate_pkg::TP_BASE + {1'b0, tpCode});
    requested.ultra = ultraWanted;
    requested.offset = transferCtrl[sync_rate_pkg::OFFSET_LSB +: 5];
  end

  // Active settings follow the request only while no transfer runs,
  // so a divider never sees its ratio change under a running period
  // Sync ratio
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      activeSync <= sync_rate_pkg::RATIO_1;
    end
    else if (!syncXferActive)
    begin
      activeSync <= requested.syncRatio;
    end
  end

  // Core ratio
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      activeCore <= sync_rate_pkg::RATIO_1;
    end
    else if (!syncXferActive)
    begin
      activeCore <= requested.coreRatio;
    end
  end

  // Send ratio
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      activeSend <= sync_rate_pkg::TP_BASE;
    end
    else if (!syncXferActive)
    begin
      activeSend <= requested.sendRatio;
    end
  end

  // Ultra mode
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      activeUltra <= 1'b0;
    end
    else if (!syncXferActive)
    begin
      activeUltra <= requested.ultra;
    end
  end

  // Offset
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      activeOffset <= 5'h00;
    end
    else if (!syncXferActive)
    begin
      activeOffset <= requested.offset;
    end
  end

  // Active settings as one record for the dividers and status
  always_comb
  begin
    active.syncRatio = activeSync;
    active.coreRatio = activeCore;
    active.sendRatio = activeSend;
    active.ultra = activeUltra;
    active.offset = activeOffset;
  end

  assign pending = (requested != active);

  // Sync clock divider from the SCSI clock
  div_tick syncDivider
  (
    .mclk(mclk),
    .rst(rst),
    .divisor(active.syncRatio),
    .advance(1'b1),
    .tick(syncTick)
  );

  // Core clock divider from the SCSI clock
  div_tick coreDivider
  (
    .mclk(mclk),
    .rst(rst),
    .divisor(active.coreRatio),
    .advance(1'b1),
    .tick(coreTick)
  );

  // Receive slots at a fixed quarter of the sync rate, never the period
  div_tick rxDivider
  (
    .mclk(mclk),
    .rst(rst),
    .divisor(sync_rate_pkg::RX_RATIO),
    .advance(syncTick),
    .tick(rxSlot)
  );

  // Send period: sync ticks divided by the transfer period divisor
  div_tick txDivider
  (
    .mclk(mclk),
    .rst(rst),
    .divisor(active.sendRatio),
    .advance(syncTick),
    .tick(txSlot)
  );

  // Active mode as seen by the transfer logic
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ultraActive <= 1'b0;
    end
    else
    begin
      ultraActive <= active.ultra;
    end
  end

  // Active offset as seen by the transfer logic
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      syncOffset <= 5'h00;
    end
    else
    begin
      syncOffset <= active.offset;
    end
  end

  // Status word showing the block's own state
  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[sync_rate_pkg::STAT_PENDING_BIT] = pending;
    statusWord[sync_rate_pkg::STAT_ULTRA_BIT] = active.ultra;
    statusWord[sync_rate_pkg::STAT_SCF_BAD_BIT] = scfBad;
    statusWord[sync_rate_pkg::STAT_CCF_BAD_BIT] = ccfBad;
  end

  // Read mux; unmapped addresses read as zero
  always_comb
  begin
    next_dat = 32'h0000_0000;
    case (adr_i)
      sync_rate_pkg::ADDR_CLOCK_CTRL: next_dat = {24'h00_0000, clockCtrl};
      sync_rate_pkg::ADDR_TRANSFER_CTRL:
        next_dat = {24'h00_0000, transferCtrl};
      sync_rate_pkg::ADDR_STATUS: next_dat = statusWord;
      default: next_dat = 32'h0000_0000;
    endcase
  end

  // Read data registered with the ack
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      dat_o <= 32'h0000_0000;
    end
    else if (busRead)
    begin
      dat_o <= next_dat;
    end
  end

endmodule // sync_scsi_rate_divider

// file: verif/sync_rate_monitor.sv
// Timing checks on the ports of the synchronous rate divider.
// Assumes one clock domain, mclk, with rst as its reset.
`timescale 1ns/1ps
module sync_rate_monitor
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire logic syncXferActive,
  input wire logic scsiClock80,
  input wire logic syncTick,
  input wire logic rxSlot,
  input wire logic txSlot,
  input wire logic ultraActive,
  input wire logic [4:0] syncOffset
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  read_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  sync_gap_a: assert property (syncTick && $past(syncTick) |->
    ultraActive || $past(ultraActive))
    else $error("sync divided by one without ultra");
  rx_align_a: assert property (rxSlot |-> $past(syncTick))
    else $error("receive slot not after sync tick");
  rx_space_a: assert property (rxSlot |=> !rxSlot [*3])
    else $error("receive slots too close");
  tx_align_a: assert property (txSlot |-> $past(syncTick))
    else $error("send slot not after sync tick");
  tx_space_a: assert property (txSlot |=> !txSlot [*3])
    else $error("send slots too close");
  frozen_cfg_a: assert property (syncXferActive [*3] |->
    $stable(syncOffset) && $stable(ultraActive))
    else $error("settings changed during transfer");
  ultra_clock_a: assert property (!scsiClock80 && !syncXferActive |->
    ##[1:2] !ultraActive)
    else $error("ultra active without fast clock");
  cover property (txSlot && ultraActive);
  cover property (rxSlot && !ultraActive);
  cover property (syncXferActive && ack_o);
endmodule // sync_rate_monitor

bind sync_scsi_rate_divider sync_rate_monitor u_sync_rate_monitor
(
  .mclk(mclk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .dat_o(dat_o), .syncXferActive(syncXferActive),
  .scsiClock80(scsiClock80), .syncTick(syncTick), .rxSlot(rxSlot),
  .txSlot(txSlot), .ultraActive(ultraActive), .syncOffset(syncOffset)
);

// file: verif/scsi_peer.sv
// Bus peer: frames synchronous transfers and reports the clock rate.
// Assumes link() is called just after a rising mclk edge.
`timescale 1ns/1ps
module scsi_peer
(
  output logic syncXferActive,
  output logic scsiClock80
);
  initial
  begin
    syncXferActive = 1'b0;
    scsiClock80 = 1'b1;
  end
  // Peer drives the transfer flag and the 80 MHz clock indication
  task link(input logic act, input logic c80);
    syncXferActive <= act;
    scsiClock80 <= c80;
  endtask
endmodule // scsi_peer

// file: verif/sync_scsi_rate_divider_tb.sv
// Bench for the rate divider: bus access, tick spacing, frozen settings.
// Assumes the peer model and the bound monitor are compiled alongside.
`timescale 1ns/1ps
module sync_scsi_rate_divider_tb;
  logic mclk, rst, cycI, stbI, weI, ackO, sTick, cTick, rx, tx, ultra;
  logic [7:0] adrI;
  logic [31:0] datI, datO, rdat;
  logic [3:0] selI;
  logic act, c80;
  logic [4:0] offs;
  int errorCnt = 0;
  int nChecks = 0;
  scsi_peer u_scsi_peer (.syncXferActive(act), .scsiClock80(c80));
  sync_scsi_rate_divider u_sync_scsi_rate_divider
  (
    .mclk(mclk), .rst(rst), .cyc_i(cycI), .stb_i(stbI), .we_i(weI),
    .adr_i(adrI), .dat_i(datI), .sel_i(selI), .dat_o(datO), .ack_o(ackO),
    .syncXferActive(act), .scsiClock80(c80), .syncTick(sTick),
    .coreTick(cTick), .rxSlot(rx), .txSlot(tx), .ultraActive(ultra),
    .syncOffset(offs)
  );
  task giveVerdict;
    $display("checks %0d errors %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    nChecks++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED at %0t: %s", $time, m);
      errorCnt++;
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    cycI <= 1'b1;
    stbI <= 1'b1;
    weI <= w;
    adrI <= a;
    datI <= d;
    selI <= s;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ackO !== 1'b1 && n < 50);
    rdat = datO;
    cycI <= 1'b0;
    stbI <= 1'b0;
    @(posedge mclk);
    if (n >= 50)
    begin
      errorCnt++;
      giveVerdict;
    end
  endtask
  function logic sig(input int w);
    return w == 0 ? sTick : w == 1 ? cTick : w == 2 ? rx : tx;
  endfunction
  // Cycles between two pulses of the chosen tick output
  task gap(input int w, output int g);
    int n;
    n = 0;
    while (sig(w) !== 1'b1 && n < 200)
    begin
      @(negedge mclk);
      n++;
    end
    g = 0;
    do
    begin
      @(negedge mclk);
      g++;
    end
    while (sig(w) !== 1'b1 && g < 200);
    @(posedge mclk);
    if (n >= 200 || g >= 200)
    begin
      errorCnt++;
      giveVerdict;
    end
  endtask
  task sReset;
    int g;
    wb(1'b0, sync_rate_pkg::ADDR_CLOCK_CTRL, 32'h0, 4'hF);
    chk(rdat, {24'h0, sync_rate_pkg::CLOCK_CTRL_RST}, "clock reset");
    wb(1'b0, sync_rate_pkg::ADDR_TRANSFER_CTRL, 32'h0, 4'hF);
    chk(rdat, {24'h0, sync_rate_pkg::TRANSFER_CTRL_RST}, "xfer reset");
    wb(1'b0, sync_rate_pkg::ADDR_STATUS, 32'h0, 4'hF);
    chk(rdat, 32'h0000000C, "status reset");
    gap(0, g);
    chk(g, 2, "reset sync gap");
  endtask
  task sMap;
    wb(1'b1, 8'h0C, 32'hFF, 4'hF);
    wb(1'b0, 8'h0C, 32'h0, 4'hF);
    chk(rdat, 32'h0, "unmapped read");
    wb(1'b1, sync_rate_pkg::ADDR_TRANSFER_CTRL, 32'h1F, 4'h0);
    wb(1'b0, sync_rate_pkg::ADDR_TRANSFER_CTRL, 32'h0, 4'hF);
    chk(rdat, 32'h0, "lane off write");
  endtask
  task sRates;
    logic [2:0] c;
    logic [7:0] x;
    int r, g;
    for (int i = 0; i < 3; i++)
    begin
      c = i == 0 ? 3'h1 : i == 1 ? 3'h3 : 3'h5;
      r = 1 << i;
      x = {3'(i), 5'(10 + i)};
      wb(1'b1, sync_rate_pkg::ADDR_CLOCK_CTRL, {24'h0, 1'b1, c, 1'b0, c},
        4'h1);
      wb(1'b1, sync_rate_pkg::ADDR_TRANSFER_CTRL, {24'h0, x}, 4'h1);
      wb(1'b0, sync_rate_pkg::ADDR_TRANSFER_CTRL, 32'h0, 4'hF);
      chk(rdat, {24'h0, x}, "xfer readback");
      repeat (60) @(posedge mclk);
      gap(0, g);
      chk(g, r, "sync gap");
      gap(1, g);
      chk(g, r, "core gap");
      gap(2, g);
      chk(g, 4 * r, "rx gap");
      gap(3, g);
      chk(g, r * (4 + i), "tx gap");
      chk(offs, 32'(10 + i), "offset");
      chk(ultra, 1'b1, "ultra on");
    end
  endtask
  task sNonUltra;
    int g;
    wb(1'b1, sync_rate_pkg::ADDR_CLOCK_CTRL, 32'h91, 4'h1);
    u_scsi_peer.link(1'b0, 1'b0);
    repeat (60) @(posedge mclk);
    gap(0, g);
    chk(g, 2, "slow clock gap");
    chk(ultra, 1'b0, "ultra off");
    u_scsi_peer.link(1'b0, 1'b1);
    @(posedge mclk);
  endtask
  task sFreeze;
    u_scsi_peer.link(1'b1, 1'b1);
    wb(1'b1, sync_rate_pkg::ADDR_TRANSFER_CTRL, 32'h15, 4'h1);
    wb(1'b0, sync_rate_pkg::ADDR_STATUS, 32'h0, 4'hF);
    chk(rdat[0], 1'b1, "pending");
    chk(offs, 32'h0C, "held offset");
    u_scsi_peer.link(1'b0, 1'b1);
    repeat (5) @(posedge mclk);
    wb(1'b0, sync_rate_pkg::ADDR_STATUS, 32'h0, 4'hF);
    chk(rdat[0], 1'b0, "pending clear");
    chk(offs, 32'h15, "new offset");
  endtask
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    rst = 1'b1;
    cycI = 1'b0;
    stbI = 1'b0;
    weI = 1'b0;
    adrI = 8'h00;
    datI = 32'h0;
    selI = 4'h0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    sReset;
    sMap;
    sRates;
    sNonUltra;
    sFreeze;
    giveVerdict;
  end
endmodule // sync_scsi_rate_divider_tb
